// ### logic/cctg_group.sv
// Capture/compare timer group: one timer core and the four-timer top
module cctg_timer #(
	parameter int NCH = 3
) (
	input wire logic clk,
	input wire logic reset,
	input cctg_pkg::cctg_tmr_cfg_t cfg,
	input wire logic [3:0] clk_src,
	input wire logic [NCH-1:0] cap_a,
	input wire logic [NCH-1:0] cap_b,
	input cctg_pkg::cctg_irq_t irq_clr,
	output cctg_pkg::cctg_irq_t irq_r,
	output logic [NCH-1:0] out_r,
	output logic [NCH-1:0][cctg_pkg::CNT_W-1:0] capt_r,
	output logic [cctg_pkg::CNT_W-1:0] count_r
);
	function automatic logic sel4(input logic [3:0] v, input logic [1:0] s);
		sel4 = v[s];
	endfunction

	function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] es);
		edge_hit = ((es == cctg_pkg::EDGE_RISE || es == cctg_pkg::EDGE_BOTH) && cur && !prev) ||
			((es == cctg_pkg::EDGE_FALL || es == cctg_pkg::EDGE_BOTH) && !cur && prev);
	endfunction

	logic tick_q_r;
	logic [NCH-1:0] in_q_r;
	logic [cctg_pkg::CNT_W-1:0] count_nxt;
	logic [NCH-1:0] in_lvl;
	logic [NCH-1:0] cap_evt;
	logic [NCH-1:0] cmp_hit;
	logic [NCH-1:0] out_nxt;
	logic [cctg_pkg::MAX_CH-1:0] ch_set;
	cctg_pkg::cctg_irq_t irq_nxt;

	// Counter advances once per rising edge of the chosen source
	wire tick_lvl = sel4(clk_src, cfg.clk_sel);
	wire tick = tick_lvl & ~tick_q_r;
	wire run = tick && (cfg.mode != cctg_pkg::MODE_STOP);
	wire [cctg_pkg::CNT_W-1:0] top = (cfg.mode == cctg_pkg::MODE_UP) ? cfg.ch[0].cmp : cctg_pkg::CNT_TOP;
	wire wrap = run && (count_r == top);
	assign count_nxt = wrap ? cctg_pkg::CNT_RST : (run ? count_r + cctg_pkg::CNT_ONE : count_r);

	// Per-channel capture, compare and output waveform
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			assign in_lvl[gi] = sel4({1'b1, 1'b0, cap_b[gi], cap_a[gi]}, cfg.ch[gi].in_sel);
			assign cap_evt[gi] = cfg.ch[gi].cap_en && edge_hit(in_q_r[gi], in_lvl[gi], cfg.ch[gi].edge_sel);
			assign cmp_hit[gi] = !cfg.ch[gi].cap_en && run && (count_r == cfg.ch[gi].cmp);
			assign out_nxt[gi] = (cfg.ch[gi].out_mode == cctg_pkg::OUT_LEVEL) ? cfg.ch[gi].out_val :
				(cfg.ch[gi].out_mode == cctg_pkg::OUT_TOGGLE) ? (out_r[gi] ^ cmp_hit[gi]) :
				(cfg.ch[gi].out_mode == cctg_pkg::OUT_RST_SET) ? (cmp_hit[gi] ? 1'b0 : (wrap ? 1'b1 : out_r[gi])) :
				(cmp_hit[gi] ? 1'b1 : (wrap ? 1'b0 : out_r[gi]));
		end
	endgenerate

	// Set wins over clear so no event is lost
	always_comb begin
		ch_set = '0;
		ch_set[NCH-1:0] = cap_evt | cmp_hit;
		irq_nxt.ovf = (irq_r.ovf & ~irq_clr.ovf) | wrap;
		irq_nxt.ch = (irq_r.ch & ~irq_clr.ch) | ch_set;
	end

	// Counter and flags
	always_ff @(posedge clk) begin
		if (reset) begin
			count_r <= cctg_pkg::CNT_RST;
			tick_q_r <= tick_lvl; // Follow the source so a high level is no edge
			irq_r <= '0;
		end else begin
			count_r <= count_nxt;
			tick_q_r <= tick_lvl;
			irq_r <= irq_nxt;
		end
	end

	// Channel state; capture holds the count seen at the edge
	always_ff @(posedge clk) begin
		if (reset) begin
			in_q_r <= in_lvl; // Supply select reads high, so no false capture
			out_r <= '0;
			capt_r <= '0;
		end else begin
			in_q_r <= in_lvl;
			out_r <= out_nxt;
			for (int i = 0; i < NCH; i++) begin
				if (cap_evt[i]) begin
					capt_r[i] <= count_r;
				end
			end
		end
	end
endmodule

module cctg_group (
	input wire logic clk,
	input wire logic reset,
	input cctg_pkg::cctg_tmr_cfg_t cfg0,
	input cctg_pkg::cctg_tmr_cfg_t cfg1,
	input cctg_pkg::cctg_tmr_cfg_t cfg2,
	input cctg_pkg::cctg_tmr_cfg_t cfg3,
	input cctg_pkg::cctg_irq_t clr0,
	input cctg_pkg::cctg_irq_t clr1,
	input cctg_pkg::cctg_irq_t clr2,
	input cctg_pkg::cctg_irq_t clr3,
	input wire logic timer_external_clock_input0,
	input wire logic timer_external_clock_input1,
	input wire logic aux_clock,
	input wire logic subsystem_master_clock,
	input wire logic comparator_output,
	input wire logic [2:0] t0_cap_pin_a,
	input wire logic channel0_capture_input_b0,
	input wire logic [2:0] t1_cap_pin_a,
	input wire logic channel0_capture_input_b1,
	output cctg_pkg::cctg_irq_t irq0,
	output cctg_pkg::cctg_irq_t irq1,
	output cctg_pkg::cctg_irq_t irq2,
	output cctg_pkg::cctg_irq_t irq3,
	output logic [cctg_pkg::PIN_CH-1:0] t0_out,
	output logic [cctg_pkg::PIN_CH-1:0] t1_out,
	output logic [cctg_pkg::INT_CH-1:0] t2_out,
	output logic [cctg_pkg::INT_CH-1:0] t3_out,
	output logic [cctg_pkg::PIN_CH-1:0][cctg_pkg::CNT_W-1:0] t0_capt,
	output logic [cctg_pkg::PIN_CH-1:0][cctg_pkg::CNT_W-1:0] t1_capt,
	output logic [cctg_pkg::INT_CH-1:0][cctg_pkg::CNT_W-1:0] t2_capt,
	output logic [cctg_pkg::INT_CH-1:0][cctg_pkg::CNT_W-1:0] t3_capt,
	output logic [cctg_pkg::CNT_W-1:0] t0_count,
	output logic [cctg_pkg::CNT_W-1:0] t1_count,
	output logic [cctg_pkg::CNT_W-1:0] t2_count,
	output logic [cctg_pkg::CNT_W-1:0] t3_count
);
	logic [cctg_pkg::SYNC_W-1:0] sync1_r;
	logic [cctg_pkg::SYNC_W-1:0] sync2_r;

	// Two-stage synchroniser; pins and foreign clocks are all asynchronous here
	// Kept out of reset so it tracks the pins: a pin resting high gives no false edge after reset
	always_ff @(posedge clk) begin
		sync1_r <= {timer_external_clock_input0, timer_external_clock_input1, aux_clock,
			subsystem_master_clock, comparator_output, t0_cap_pin_a, channel0_capture_input_b0,
			t1_cap_pin_a, channel0_capture_input_b1};
		sync2_r <= sync1_r;
	end

	// Named views of the synchronised inputs
	wire ext0 = sync2_r[12];
	wire ext1 = sync2_r[11];
	wire aux_s = sync2_r[10];
	wire sub_s = sync2_r[9];
	wire cmp_s = sync2_r[8];
	wire [2:0] t0_a = sync2_r[7:5];
	wire t0_b0 = sync2_r[4];
	wire [2:0] t1_a = sync2_r[3:1];
	wire t1_b0 = sync2_r[0];

	// Pin timers: alternate clock shares the external clock pin
	cctg_timer #(.NCH(cctg_pkg::PIN_CH)) u_t0 (
		.clk(clk),
		.reset(reset),
		.cfg(cfg0),
		.clk_src({ext0, sub_s, aux_s, ext0}),
		.cap_a(t0_a),
		.cap_b({aux_s, cmp_s, t0_b0}),
		.irq_clr(clr0),
		.irq_r(irq0),
		.out_r(t0_out),
		.capt_r(t0_capt),
		.count_r(t0_count)
	);

	cctg_timer #(.NCH(cctg_pkg::PIN_CH)) u_t1 (
		.clk(clk),
		.reset(reset),
		.cfg(cfg1),
		.clk_src({ext1, sub_s, aux_s, ext1}),
		.cap_a(t1_a),
		.cap_b({aux_s, cmp_s, t1_b0}),
		.irq_clr(clr1),
		.irq_r(irq1),
		.out_r(t1_out),
		.capt_r(t1_capt),
		.count_r(t1_count)
	);

	// Internal timers feed each other's channel 0 input A; channel 1 input A has no source
	cctg_timer #(.NCH(cctg_pkg::INT_CH)) u_t2 (
		.clk(clk),
		.reset(reset),
		.cfg(cfg2),
		.clk_src({cmp_s, sub_s, aux_s, cmp_s}),
		.cap_a({1'b0, t3_out[0]}),
		.cap_b({cmp_s, aux_s}),
		.irq_clr(clr2),
		.irq_r(irq2),
		.out_r(t2_out),
		.capt_r(t2_capt),
		.count_r(t2_count)
	);

	cctg_timer #(.NCH(cctg_pkg::INT_CH)) u_t3 (
		.clk(clk),
		.reset(reset),
		.cfg(cfg3),
		.clk_src({cmp_s, sub_s, aux_s, cmp_s}),
		.cap_a({1'b0, t2_out[0]}),
		.cap_b({cmp_s, aux_s}),
		.irq_clr(clr3),
		.irq_r(irq3),
		.out_r(t3_out),
		.capt_r(t3_capt),
		.count_r(t3_count)
	);
endmodule

// ### logic/cctg_pkg.sv
// Shared constants and carrier types for the capture/compare timer group
package cctg_pkg;
	localparam int CNT_W = 16;
	localparam int MAX_CH = 3;
	localparam int PIN_CH = 3;
	localparam int INT_CH = 2;
	localparam int SYNC_W = 13;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_TOP = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	// Counter clock source select codes
	localparam logic [1:0] CLK_EXT = 2'h0;
	localparam logic [1:0] CLK_AUX = 2'h1;
	localparam logic [1:0] CLK_SUB = 2'h2;
	localparam logic [1:0] CLK_ALT = 2'h3;
	// Capture input select codes
	localparam logic [1:0] IN_A = 2'h0;
	localparam logic [1:0] IN_B = 2'h1;
	localparam logic [1:0] IN_GND = 2'h2;
	localparam logic [1:0] IN_VCC = 2'h3;
	// Capture edge select codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Channel output modes
	localparam logic [1:0] OUT_LEVEL = 2'h0;
	localparam logic [1:0] OUT_TOGGLE = 2'h1;
	localparam logic [1:0] OUT_RST_SET = 2'h2;
	localparam logic [1:0] OUT_SET_RST = 2'h3;

	typedef enum logic [2:0] {
		MODE_STOP = 3'h1,
		MODE_UP = 3'h2,
		MODE_CONT = 3'h4
	} cctg_mode_t;

	typedef struct packed {
		logic cap_en;
		logic [1:0] in_sel;
		logic [1:0] edge_sel;
		logic [1:0] out_mode;
		logic out_val;
		logic [CNT_W-1:0] cmp;
	} cctg_chan_cfg_t;

	typedef struct packed {
		cctg_mode_t mode;
		logic [1:0] clk_sel;
		cctg_chan_cfg_t [MAX_CH-1:0] ch;
	} cctg_tmr_cfg_t;

	typedef struct packed {
		logic ovf;
		logic [MAX_CH-1:0] ch;
	} cctg_irq_t;
endpackage

// ### tb/cctg_checker.sv
// Assertions on timer 0 of the timer group
module cctg_checker (
	input wire logic clk,
	input wire logic reset,
	input cctg_pkg::cctg_tmr_cfg_t cfg0,
	input cctg_pkg::cctg_irq_t clr0,
	input cctg_pkg::cctg_irq_t irq0,
	input wire logic [2:0] t0_out,
	input wire logic [2:0][15:0] t0_capt,
	input wire logic [15:0] t0_count
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Count drops to zero, not by reset
	sequence s_wrap;
		!$past(reset) && $past(t0_count) != '0 && t0_count == '0;
	endsequence
	// Reset override: checked while reset is high
	property p_rst;
		disable iff (1'b0) reset |=> t0_count == '0 && irq0 == '0 && t0_out == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_step;
		!$stable(t0_count) |-> t0_count == $past(t0_count) + 16'h0001 || t0_count == '0;
	endproperty
	a_step: assert property (p_step) else $error("count step");
	property p_wrap; s_wrap |-> irq0.ovf; endproperty
	a_wrap: assert property (p_wrap) else $error("wrap without flag");
	property p_ovf; $rose(irq0.ovf) |-> t0_count == '0; endproperty
	a_ovf: assert property (p_ovf) else $error("flag without wrap");
	// Reset zeroes the capture, so skip that edge
	property p_cap; !$past(reset) && $changed(t0_capt[2]) |-> irq0.ch[2]; endproperty
	a_cap: assert property (p_cap) else $error("capture flag");
	property p_lvl;
		cfg0.ch[1].out_mode == cctg_pkg::OUT_LEVEL |=> t0_out[1] == $past(cfg0.ch[1].out_val);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level output");
	property p_clr; $fell(irq0.ch[1]) |-> $past(clr0.ch[1]) || $past(reset); endproperty
	a_clr: assert property (p_clr) else $error("flag lost");
	property p_hit;
		$rose(irq0.ch[1]) && !$past(cfg0.ch[1].cap_en) |-> $past(t0_count) == $past(cfg0.ch[1].cmp);
	endproperty
	a_hit: assert property (p_hit) else $error("compare flag");
endmodule

bind cctg_group cctg_checker chk_u (.clk, .reset, .cfg0, .clr0, .irq0, .t0_out, .t0_capt, .t0_count);

// ### tb/tb_top.sv
// Self-checking bench for the timer group
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, sm = 0;
	logic [2:0] pa = '0, t0_out;
	logic [2:0][15:0] t0_capt, t1_capt;
	logic [15:0] t0_count, t1_count, t2_count, t3_count, top, k, c;
	cctg_pkg::cctg_tmr_cfg_t cfg0 = '0;
	cctg_pkg::cctg_irq_t clr0 = '0, irq0, irq2;
	int err_count = 0, total_checks = 0, seed = 32'h7F52051C, n, nr;
	// All clock sources share one slow line, so any select counts alike
	cctg_group dut_u (.clk, .reset, .cfg0, .cfg1(cfg0), .cfg2(cfg0), .cfg3(cfg0), .clr0, .clr1(clr0),
		.clr2(clr0), .clr3(clr0), .timer_external_clock_input0(sm), .timer_external_clock_input1(sm),
		.aux_clock(sm), .subsystem_master_clock(sm), .comparator_output(sm), .t0_cap_pin_a(pa),
		.t1_cap_pin_a(pa), .channel0_capture_input_b0(pa[0]), .channel0_capture_input_b1(pa[1]), .irq0,
		.irq1(), .irq2, .irq3(), .t0_out, .t1_out(), .t2_out(), .t3_out(), .t0_capt, .t1_capt,
		.t2_capt(), .t3_capt(), .t0_count, .t1_count, .t2_count, .t3_count);
	// Count after n ticks with wrap at top
	function automatic logic [15:0] exp_cnt(int n, logic [15:0] t);
		return n % (t + 1);
	endfunction
	// Channel output after n ticks; a hit beats a wrap on the same tick
	function automatic logic exp_out(int n, logic [15:0] t, logic [15:0] k, logic [1:0] m, logic v);
		logic o = 1'b0;
		logic [15:0] cc = 16'h0000;
		if (m == cctg_pkg::OUT_LEVEL) return v;
		for (int j = 0; j < n; j++) begin
			if (cc == k) o = (m == cctg_pkg::OUT_TOGGLE) ? !o : (m == cctg_pkg::OUT_SET_RST);
			else if (cc == t && m != cctg_pkg::OUT_TOGGLE) o = (m == cctg_pkg::OUT_RST_SET);
			cc = (cc == t) ? 16'h0000 : cc + 16'h0001;
		end
		return o;
	endfunction
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// Each level held well past the synchroniser
	task automatic tick(int n);
		repeat (n) begin
			@(negedge clk) sm = 1;
			repeat (4) @(negedge clk);
			sm = 0;
			repeat (4) @(negedge clk);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		forever #20 clk = ~clk;
	end
	// Watchdog far beyond eight rounds
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
	// Rounds: zero top first, free running, then stopped; output mode steps through all four
	initial begin
		repeat (8) @(negedge clk);
		for (int r = 0; r < 8; r++) begin
			reset = 1;
			top = r == 5 ? 16'hFFFF : r == 0 ? 16'h0000 : 16'(16'h0002 + ($random(seed) & 16'h000F));
			k = 16'($random(seed) & 16'h0007);
			n = $random(seed) & 31;
			nr = r == 6 ? 0 : n;
			cfg0.mode = r == 5 ? cctg_pkg::MODE_CONT : r == 6 ? cctg_pkg::MODE_STOP : cctg_pkg::MODE_UP;
			cfg0.clk_sel = 2'($random(seed));
			cfg0.ch[0].cmp = top;
			cfg0.ch[1].cmp = k;
			cfg0.ch[1].out_mode = 2'(r);
			cfg0.ch[1].out_val = r[2];
			cfg0.ch[2].cap_en = 1;
			cfg0.ch[2].in_sel = r[0] ? cctg_pkg::IN_A : r[1] ? cctg_pkg::IN_VCC : cctg_pkg::IN_GND;
			cfg0.ch[2].edge_sel = cctg_pkg::EDGE_RISE;
			@(negedge clk) reset = 0;
			// First edges out of reset settle the outputs even when no tick follows
			repeat (2) @(negedge clk);
			tick(n);
			chk("count", exp_cnt(nr, top), t0_count);
			chk("t1 count", exp_cnt(nr, top), t1_count);
			chk("t2 count", exp_cnt(nr, top), t2_count);
			chk("t3 count", exp_cnt(nr, top), t3_count);
			chk("overflow", nr > top, irq0.ovf);
			chk("hit", nr > k && k <= top, irq0.ch[1]);
			chk("output", exp_out(nr, top, k, 2'(r), r[2]), t0_out[1]);
			c = r[0] ? t0_count : 16'h0000;
			pa[2] = 1;
			repeat (6) @(negedge clk);
			chk("capture", c, t0_capt[2]);
			chk("t1 capture", c, t1_capt[2]);
			chk("capflag", r[0], irq0.ch[2]);
			chk("t2 no ch2", 0, irq2.ch[2]);
			pa[2] = 0;
			clr0 = '1;
			@(negedge clk) clr0 = '0;
			@(negedge clk) chk("cleared", 0, irq0);
		end
		final_report();
	end
endmodule
